// [design/two_wire_defines.vh]
// Constants for the two-wire master handshake block
`ifndef TWO_WIRE_DEFINES_VH
`define TWO_WIRE_DEFINES_VH
// APB byte offsets
`define OFF_CONTROL     12'h000
`define OFF_STATUS      12'h004
`define OFF_DATA        12'h008
`define OFF_RATE        12'h00C
`define OFF_CPU         12'h010
// Control register bit positions
`define CTL_FLAG        7
`define CTL_ACK_EN      6
`define CTL_START       5
`define CTL_STOP        4
`define CTL_WCOL        3
`define CTL_ENABLE      2
`define CTL_IRQ_EN      0
// Status codes (already placed in bits 7..3)
`define ST_START        8'h08
`define ST_RSTART       8'h10
`define ST_ADDR_ACK     8'h18
`define ST_ADDR_NACK    8'h20
`define ST_DATA_ACK     8'h28
`define ST_DATA_NACK    8'h30
`define ST_IDLE         8'hF8
// Reset values
`define DATA_RESET      8'hFF
`define RATE_RESET      8'h00
// Default quarter-bit length in pclk cycles
`define QUARTER_DEFAULT 16
`endif

// [design/two_wire_unit.v]
// Two-wire master handshake: APB registers, flag handshake and bus sequencer
`include "two_wire_defines.vh"
`default_nettype none
module two_wire_unit
#(
   parameter QUARTER = `QUARTER_DEFAULT
)
(
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Two-wire bus pins
   input  wire        scl_in,
   output reg         scl_out,
   output reg         scl_oe,
   input  wire        sda_in,
   output reg         sda_out,
   output reg         sda_oe,
   // Interrupt request
   output reg         irq
);

   // Sequencer states
   localparam S_IDLE   = 3'd0;
   localparam S_WAIT   = 3'd1;
   localparam S_START  = 3'd2;
   localparam S_BYTE   = 3'd3;
   localparam S_STOP   = 3'd4;
   localparam S_HOLD   = 3'd5;
   // Status codes in byte form, cut to their five code bits where loaded
   localparam [7:0] CODE_START     = `ST_START;
   localparam [7:0] CODE_RSTART    = `ST_RSTART;
   localparam [7:0] CODE_ADDR_ACK  = `ST_ADDR_ACK;
   localparam [7:0] CODE_ADDR_NACK = `ST_ADDR_NACK;
   localparam [7:0] CODE_DATA_ACK  = `ST_DATA_ACK;
   localparam [7:0] CODE_DATA_NACK = `ST_DATA_NACK;

   // Software visible state
   reg        flag_reg;            // Operation complete
   reg        ack_en_reg;          // Acknowledge enable (stored only)
   reg        start_req_reg;       // START request
   reg        stop_req_reg;        // STOP request
   reg        wcol_reg;            // Write collision
   reg        enable_reg;          // Unit enable
   reg        irq_en_reg;          // Interrupt enable
   reg        gie_reg;             // Global interrupt enable
   reg  [4:0] code_reg;            // Status code
   reg  [1:0] prescale_reg;        // Rate prescale field
   reg  [7:0] data_reg;            // Shift and data register
   reg  [7:0] rate_reg;            // Bit rate (stored only)
   // Sequencer
   reg  [2:0] state_reg;
   reg        addr_phase_reg;      // Next byte is the address
   reg        owner_reg;           // We hold the bus
   reg  [3:0] bit_reg;             // Bit index, 8 is ack slot
   reg  [1:0] phase_reg;           // Quarter within bit
   reg [15:0] tick_reg;            // Quarter timer
   reg        go_reg;              // Flag just cleared by software, or flag written while S_IDLE
   // Pin synchronisers and edge tracking
   reg        scl_s1_reg;
   reg        scl_s2_reg;
   reg        sda_s1_reg;
   reg        sda_s2_reg;
   reg        sda_old_reg;
   reg        busy_reg;            // Some master holds the bus

   // APB decode
   wire       wr = psel & penable & pwrite;
   wire       rd = psel & ~penable & ~pwrite;
   wire       hit = (paddr == `OFF_CONTROL) | (paddr == `OFF_STATUS) |
                    (paddr == `OFF_DATA) | (paddr == `OFF_RATE) |
                    (paddr == `OFF_CPU);
   wire       wr_ctl  = wr & (paddr == `OFF_CONTROL);
   wire       wr_data = wr & (paddr == `OFF_DATA);
   wire       tick    = (tick_reg == 16'd0);
   wire       set_ev;              // Hardware completion event
   reg        ev_reg;
   reg  [4:0] ev_code_reg;

   // Bus-free detector on synchronised pins
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_s1_reg  <= 1'b1;
         scl_s2_reg  <= 1'b1;
         sda_s1_reg  <= 1'b1;
         sda_s2_reg  <= 1'b1;
         sda_old_reg <= 1'b1;
         busy_reg    <= 1'b0;
      end
      else
      begin
         scl_s1_reg  <= scl_in;
         scl_s2_reg  <= scl_s1_reg;
         sda_s1_reg  <= sda_in;
         sda_s2_reg  <= sda_s1_reg;
         sda_old_reg <= sda_s2_reg;
         // Falling data with clock high: START; rising: STOP
         if (scl_s2_reg && sda_old_reg && !sda_s2_reg)
            busy_reg <= 1'b1;
         else if (scl_s2_reg && !sda_old_reg && sda_s2_reg)
            busy_reg <= 1'b0;
      end
   end

   assign set_ev = ev_reg;

   // APB registers and the flag handshake
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_reg      <= 1'b0;
         ack_en_reg    <= 1'b0;
         start_req_reg <= 1'b0;
         stop_req_reg  <= 1'b0;
         wcol_reg      <= 1'b0;
         enable_reg    <= 1'b0;
         irq_en_reg    <= 1'b0;
         gie_reg       <= 1'b0;
         code_reg      <= 5'h1F;
         prescale_reg  <= 2'b00;
         rate_reg      <= `RATE_RESET;
         go_reg        <= 1'b0;
         prdata        <= 32'h0000_0000;
         pready        <= 1'b0;
         pslverr       <= 1'b0;
         irq           <= 1'b0;
      end
      else
      begin
         go_reg  <= 1'b0;
         pready  <= psel & ~penable;      // No wait state: pready is high in the first access cycle
         pslverr <= psel & ~penable & ~hit;
         // Read data captured in the setup cycle
         if (rd)
         begin
            case (paddr)
               `OFF_CONTROL: prdata <= {24'h0, flag_reg, ack_en_reg, start_req_reg,
                                        stop_req_reg, wcol_reg, enable_reg, 1'b0,
                                        irq_en_reg};
               `OFF_STATUS:  prdata <= {24'h0, code_reg, 1'b0, prescale_reg};
               `OFF_DATA:    prdata <= {24'h0, data_reg};
               `OFF_RATE:    prdata <= {24'h0, rate_reg};
               `OFF_CPU:     prdata <= {31'h0, gie_reg};
               default:      prdata <= 32'h0000_0000;
            endcase
         end
         // Control writes
         if (wr_ctl)
         begin
            ack_en_reg    <= pwdata[`CTL_ACK_EN];
            start_req_reg <= pwdata[`CTL_START];
            enable_reg    <= pwdata[`CTL_ENABLE];
            irq_en_reg    <= pwdata[`CTL_IRQ_EN];
         end
         // Stop request: written by software, cleared once STOP is done
         if (state_reg == S_STOP && bit_reg == 4'd2 && tick)
            stop_req_reg <= 1'b0;
         else if (wr_ctl)
            stop_req_reg <= pwdata[`CTL_STOP];
         if (wr & (paddr == `OFF_STATUS))
            prescale_reg <= pwdata[1:0];
         if (wr & (paddr == `OFF_RATE))
            rate_reg <= pwdata[7:0];
         if (wr & (paddr == `OFF_CPU))
            gie_reg <= pwdata[0];
         // Flag: hardware set wins over software clear
         if (set_ev)
         begin
            flag_reg <= 1'b1;
            code_reg <= ev_code_reg;
         end
         else if (wr_ctl && pwdata[`CTL_FLAG] && flag_reg)
         begin
            flag_reg <= 1'b0;
            go_reg   <= 1'b1;
         end
         else if (wr_ctl && pwdata[`CTL_FLAG] && state_reg == S_IDLE)
            go_reg <= 1'b1;              // First START needs no pending flag
         // Collision flag follows data writes
         if (wr_data)
            wcol_reg <= ~flag_reg;
         // Interrupt request
         irq <= (flag_reg | set_ev) & irq_en_reg & gie_reg;
      end
   end

   // Bus sequencer, drives pins and shifts the data register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg      <= S_IDLE;
         addr_phase_reg <= 1'b0;
         owner_reg      <= 1'b0;
         bit_reg        <= 4'd0;
         phase_reg      <= 2'd0;
         tick_reg       <= 16'd0;
         data_reg       <= `DATA_RESET;
         ev_reg         <= 1'b0;
         ev_code_reg    <= 5'h1F;
         scl_out        <= 1'b0;
         scl_oe         <= 1'b0;
         sda_out        <= 1'b0;
         sda_oe         <= 1'b0;
      end
      else
      begin
         ev_reg   <= 1'b0;
         tick_reg <= tick ? QUARTER[15:0] - 16'd1 : tick_reg - 16'd1;
         // Data register writable only while idle at the flag
         if (wr_data && flag_reg)
            data_reg <= pwdata[7:0];
         case (state_reg)
            S_IDLE, S_HOLD:
            begin
               // Clock stays low while the flag is up; only a phase lets it go
               if (owner_reg && flag_reg)
                  scl_oe <= 1'b1;
               if (go_reg && enable_reg && !flag_reg)
               begin
                  bit_reg   <= 4'd0;
                  phase_reg <= 2'd0;
                  if (stop_req_reg)
                     state_reg <= S_STOP;
                  else if (start_req_reg)
                     state_reg <= S_WAIT;
                  else if (owner_reg)
                     state_reg <= S_BYTE;
               end
            end
            S_WAIT:
            begin
               // Own a held bus already, or wait for it to go free
               if (owner_reg || !busy_reg)
                  state_reg <= S_START;
            end
            S_START:
            begin
               // Release data and clock, then pull data low, then clock
               if (tick)
               begin
                  phase_reg <= phase_reg + 2'd1;
                  case (phase_reg)
                     2'd0: sda_oe <= 1'b0;
                     2'd1: scl_oe <= 1'b0;
                     2'd2: sda_oe <= 1'b1;
                     default:
                     begin
                        scl_oe         <= 1'b1;
                        ev_code_reg    <= owner_reg ? CODE_RSTART[7:3] : CODE_START[7:3];
                        owner_reg      <= 1'b1;
                        addr_phase_reg <= 1'b1;
                        ev_reg         <= 1'b1;
                        state_reg      <= S_HOLD;
                     end
                  endcase
               end
            end
            S_BYTE:
            begin
               // Four quarters per bit: set data, raise clock, sample, lower
               if (tick)
               begin
                  phase_reg <= phase_reg + 2'd1;
                  case (phase_reg)
                     2'd0: sda_oe <= (bit_reg == 4'd8) ? 1'b0 : ~data_reg[7];
                     2'd1: scl_oe <= 1'b0;
                     2'd2:
                     begin
                        if (bit_reg != 4'd8)
                           data_reg <= {data_reg[6:0], sda_s2_reg};
                        else
                           ev_code_reg <= addr_phase_reg ?
                              (sda_s2_reg ? CODE_ADDR_NACK[7:3] : CODE_ADDR_ACK[7:3]) :
                              (sda_s2_reg ? CODE_DATA_NACK[7:3] : CODE_DATA_ACK[7:3]);
                     end
                     default:
                     begin
                        scl_oe  <= 1'b1;
                        bit_reg <= bit_reg + 4'd1;
                        if (bit_reg == 4'd8)
                        begin
                           addr_phase_reg <= 1'b0;
                           ev_reg         <= 1'b1;
                           state_reg      <= S_HOLD;
                        end
                     end
                  endcase
               end
            end
            S_STOP:
            begin
               // Data low, clock high, then data high: no flag afterwards
               if (tick)
               begin
                  bit_reg <= bit_reg + 4'd1;
                  case (bit_reg)
                     4'd0: sda_oe <= 1'b1;
                     4'd1: scl_oe <= 1'b0;
                     default:
                     begin
                        sda_oe    <= 1'b0;
                        owner_reg <= 1'b0;
                        state_reg <= S_IDLE;
                     end
                  endcase
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// [bench/two_wire_unit_chk.sv]
// Port checker for the two-wire master handshake block
`include "two_wire_defines.vh"
`default_nettype none
module two_wire_unit_chk
#(
   parameter QUARTER = 16
)
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB side
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Bus pins and interrupt
   input wire logic        scl_in,
   input wire logic        scl_out,
   input wire logic        scl_oe,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIM = 16 * QUARTER; // Bound on a START
   logic acc;   // Accepted access
   logic ien_h; // Interrupt enable as written
   logic gie_h; // Global enable as written
   assign acc = psel && penable && pready;
   // Track enable bits at the accepting edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ien_h <= 1'b0;
         gie_h <= 1'b0;
      end
      else if (acc && pwrite)
      begin
         if (paddr == `OFF_CONTROL)
            ien_h <= pwdata[`CTL_IRQ_EN];
         if (paddr == `OFF_CPU)
            gie_h <= pwdata[0];
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not one pulse");
   chk_unmapped_err: assert property (acc && paddr > `OFF_CPU |-> pslverr)
      else $error("no error on unmapped read");
   chk_status_form: assert property (acc && !pwrite && paddr == `OFF_STATUS |-> !prdata[2])
      else $error("status bit 2 set");
   chk_irq_gate: assert property (irq |-> (ien_h || $past(ien_h)) && (gie_h || $past(gie_h)))
      else $error("irq without enables");
   chk_scl_hold: assert property (irq |-> scl_oe)
      else $error("clock line free while flag set");
   chk_flag_freeze: assert property (irq ##1 irq |-> $past(sda_oe) == $past(sda_oe, 2)
      && $past(scl_oe) == $past(scl_oe, 2))
      else $error("bus moved while flag set");
   chk_start_hold: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:LIM] scl_oe)
      else $error("no clock hold after start");
   chk_stop_quiet: assert property ($fell(sda_oe) && !scl_oe |=> (!scl_oe && !irq) [*8])
      else $error("activity after stop");
endmodule
bind two_wire_unit two_wire_unit_chk #(.QUARTER(QUARTER)) chk_i
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq)
);
`default_nettype wire

// [bench/tw_slave_model.sv]
// Behavioural slave: shifts in bytes and answers the acknowledge slot
`default_nettype none
module tw_slave_model
(
   // Wire levels
   input  wire logic      scl,
   input  wire logic      sda,
   // Acknowledge choice
   input  wire logic      ack_on,
   // Data pull and last byte
   output var logic       sda_pull,
   output var logic [7:0] got_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt; // Bits since START, STOP or the last acknowledge slot
   initial
   begin
      sda_pull = 1'b0;
      got_byte = 8'h00;
      cnt = 0;
   end
   // Data moving under a high clock marks START or STOP
   always @(sda)
   begin
      if (scl === 1'b1)
         cnt = 0;
   end
   // Shift in on the rising clock
   always @(posedge scl)
   begin
      if (cnt < 8)
         got_byte = {got_byte[6:0], sda};
      cnt = cnt + 1;
   end
   // Pull for the acknowledge slot, then let go
   always @(negedge scl)
   begin
      if (cnt == 8)
         sda_pull <= ack_on;
      else if (cnt == 9)
      begin
         sda_pull <= 1'b0;
         cnt = 0;
      end
   end
endmodule
`default_nettype wire

// [bench/two_wire_unit_tb.sv]
// Self-checking bench of the two-wire master handshake block
`include "two_wire_defines.vh"
`default_nettype none
module two_wire_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn;                           // Clock, reset
   logic        psel, penable, pwrite, pready, pslverr;  // APB controls
   logic [11:0] paddr;                                   // APB address
   logic [31:0] pwdata, prdata;                          // APB data
   logic        scl_oe, sda_oe, irq, ack_on, sda_pull;   // Pins, slave
   logic [7:0]  got_byte;                                // Byte at slave
   logic        scl_o, sda_o;                            // Driven pin levels
   wire logic   scl_line, sda_line;                      // Pulled-up wires
   int          err_total, n_checks, cyc;                // Counters
   assign scl_line = scl_oe ? 1'b0 : 1'b1;
   assign sda_line = (sda_oe || sda_pull) ? 1'b0 : 1'b1;
   two_wire_unit #(.QUARTER(8)) dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_in(scl_line), .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_o),
      .sda_oe(sda_oe), .irq(irq)
   );
   tw_slave_model slave
   (
      .scl(scl_line), .sda(sda_line), .ack_on(ack_on), .sda_pull(sda_pull), .got_byte(got_byte)
   );
   // Clock at 200 MHz
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Cut a hang short
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      begin
         $display("checks %0d mismatches %0d", n_checks, err_total);
         if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   function automatic logic [31:0] z(input logic [7:0] v);
      return {24'h000000, v};
   endfunction
   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_checks++;
         if (got !== exp)
         begin
            err_total++;
            $display("mismatch at %0t: word %h not %h", $time, got, exp);
         end
      end
   endtask
   task automatic chk_b(input logic got, input logic exp);
      begin
         n_checks++;
         if (got !== exp)
         begin
            err_total++;
            $display("mismatch at %0t: bit %b not %b", $time, got, exp);
         end
      end
   endtask
   // One APB transfer: setup, then access held until pready at a rising edge
   task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic er);
      int n;
      begin
         n = 0;
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= is_wr;
         paddr <= a;
         pwdata <= wd;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1 && n < 20)
         begin
            @(posedge pclk);
            n++;
         end
         if (n >= 20)
         begin
            err_total++;
            $display("mismatch at %0t: no pready", $time);
         end
         rdat = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      begin
         apb(1'b1, a, d, r, e);
      end
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      logic e;
      begin
         apb(1'b0, a, 32'h00000000, d, e);
      end
   endtask
   // Poll a control bit until it reads the wanted value
   task automatic poll(input int b, input logic v, output logic [31:0] d);
      int n;
      begin
         n = 0;
         rd(`OFF_CONTROL, d);
         while (d[b] !== v && n < 200)
         begin
            rd(`OFF_CONTROL, d);
            n++;
         end
      end
   endtask
   // Reset values and an unmapped read
   task automatic t_reset_map();
      logic [31:0] d;
      logic e;
      begin
         rd(`OFF_CONTROL, d);
         chk_w(d, 32'h00000000);
         rd(`OFF_STATUS, d);
         chk_w(d, z(`ST_IDLE));
         rd(`OFF_DATA, d);
         chk_w(d, z(`DATA_RESET));
         apb(1'b0, 12'h020, 32'h00000000, d, e);
         chk_b(e, 1'b1);
      end
   endtask
   // Data write while the flag is low is refused
   task automatic t_collision();
      logic [31:0] d;
      begin
         wr(`OFF_DATA, 32'h00000033);
         rd(`OFF_CONTROL, d);
         chk_b(d[`CTL_WCOL], 1'b1);
         rd(`OFF_DATA, d);
         chk_w(d, z(`DATA_RESET));
      end
   endtask
   // START, address, data or repeated START, then STOP
   task automatic t_transfer(input logic gie, input logic ien, input logic ack_a,
                             input logic ack_d);
      logic [31:0] d;
      logic [7:0]  c;
      begin
         c = {7'h42, ien};
         ack_on <= ack_a;
         wr(`OFF_CPU, {31'h00000000, gie});
         wr(`OFF_CONTROL, z(c | 8'h20));
         poll(7, 1'b1, d);
         chk_b(d[7], 1'b1);
         chk_b(irq, gie & ien);
         chk_b(scl_line, 1'b0);
         chk_b(scl_o | sda_o, 1'b0);
         wr(`OFF_CONTROL, z(c & 8'h7F));
         rd(`OFF_CONTROL, d);
         chk_b(d[7], 1'b1);
         rd(`OFF_STATUS, d);
         chk_w(d, z(`ST_START));
         wr(`OFF_DATA, 32'h000000A4);
         rd(`OFF_CONTROL, d);
         chk_b(d[`CTL_WCOL], 1'b0);
         wr(`OFF_CONTROL, z(c));
         poll(7, 1'b1, d);
         chk_w(z(got_byte), 32'h000000A4);
         rd(`OFF_STATUS, d);
         chk_w(d, z(ack_a ? `ST_ADDR_ACK : `ST_ADDR_NACK));
         if (ack_a)
         begin
            ack_on <= ack_d;
            wr(`OFF_DATA, 32'h0000005A);
            wr(`OFF_CONTROL, z(c));
            poll(7, 1'b1, d);
            chk_w(z(got_byte), 32'h0000005A);
            rd(`OFF_STATUS, d);
            chk_w(d, z(ack_d ? `ST_DATA_ACK : `ST_DATA_NACK));
         end
         else
         begin
            wr(`OFF_CONTROL, z(c | 8'h20));
            poll(7, 1'b1, d);
            rd(`OFF_STATUS, d);
            chk_w(d, z(`ST_RSTART));
         end
         wr(`OFF_CONTROL, z(c | 8'h10));
         poll(4, 1'b0, d);
         chk_b(d[4], 1'b0);
         rd(`OFF_CONTROL, d);
         chk_b(d[7], 1'b0);
         rd(`OFF_STATUS, d);
         chk_w(d, z(!ack_a ? `ST_RSTART : (ack_d ? `ST_DATA_ACK : `ST_DATA_NACK)));
      end
   endtask
   // Main sequence
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      ack_on = 1'b0;
      err_total = 0;
      n_checks = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_map();
      t_collision();
      t_transfer(1'b1, 1'b0, 1'b1, 1'b1);
      t_transfer(1'b1, 1'b1, 1'b0, 1'b0);
      t_transfer(1'b0, 1'b1, 1'b1, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
